/* File: common/amqp_pkg.sv */
// Purpose: Shared constants and types for the array port block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Widths fixed at build
package amqp_pkg;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned RD_LAT        = 1;
    localparam int unsigned FIFO_DEPTH    = 16;
    localparam int unsigned FIFO_AW       = 4;
    localparam int unsigned CNT_W         = 8;
    localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;

    typedef enum logic [5:0] {
        AMQP_IDLE  = 6'b000001,
        AMQP_QRD   = 6'b000010,
        AMQP_MRD   = 6'b000100,
        AMQP_MWAIT = 6'b001000,
        AMQP_QWR   = 6'b010000,
        AMQP_MWR   = 6'b100000
    } amqp_state_t;
endpackage : amqp_pkg

/* File: common/amqp_stream_if.sv */
// Purpose: Valid/ready word stream between block modules
// Assumes: Single clock
// Notes:   src drives data, snk drains it
`timescale 1ns/1ps
interface amqp_stream_if;
    import amqp_pkg::*;
    logic [DATA_W-1:0] data;
    logic              valid;
    logic              ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : amqp_stream_if

/* File: rtl/amqp_fifo.sv */
// Purpose: Parameterised word FIFO with valid/ready on both sides
// Assumes: Synchronous reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
module amqp_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } amqp_fifo_st_t;

    amqp_fifo_st_t    s_q;
    amqp_fifo_st_t    s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (s_q.cnt != DEPTH[AW:0]);
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = mem_q[s_q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wp = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
        if (push) begin
            mem_q[s_q.wp] <= in_data;
        end
    end
endmodule : amqp_fifo

/* File: rtl/amqp_array_ports.sv */
// Purpose: Array argument ports: random-access memory port and sequential queue ports
// Assumes: Single clock, inputs synchronous, external RAM read latency RD_LAT
// Notes:   Core copies queue words into RAM, then reads them back out to a queue
//
// How it works
// - Array argument shown as RAM port: address, chip-enable, write-enable, data.
// - No port activity until the start request arrives.
// - Reads drive the address with chip-enable in the same cycle.
// - Read data sampled one cycle after the read request by default.
// - Writes assert chip-enable and write-enable with address and write data.
// - Each queue port only reads or only writes, never both.
// - Stall on input queue read while not-empty is low.
// - Read strobe high in the cycle a word is taken.
// - Output word held on data while not-full is low, stalling.
// - Write strobe marks word valid once not-full is high.
// - Last-write output rises when the final queue write completes.
`timescale 1ns/1ps
module amqp_array_ports (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire logic                   block_start_request,
    input  wire logic [amqp_pkg::CNT_W-1:0] xfer_len,
    output logic                        busy,
    output logic [amqp_pkg::ADDR_W-1:0] mem_addr,
    output logic                        mem_chip_en,
    output logic                        mem_write_en,
    output logic [amqp_pkg::DATA_W-1:0] mem_write_data,
    input  wire logic [amqp_pkg::DATA_W-1:0] mem_read_data,
    input  wire logic [amqp_pkg::DATA_W-1:0] inq_data,
    input  wire logic                   inq_not_empty,
    output logic                        inq_read,
    output logic [amqp_pkg::DATA_W-1:0] outq_data,
    input  wire logic                   outq_not_full,
    output logic                        outq_write,
    output logic                        outq_last_write
);
    import amqp_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        amqp_state_t       st;
        logic [CNT_W-1:0]  len;
        logic [CNT_W-1:0]  idx;
        logic [CNT_W-1:0]  lat;
        logic [CNT_W-1:0]  sent;
        logic [ADDR_W-1:0] addr;
        logic              ce;
        logic              we;
        logic [DATA_W-1:0] wdata;
        logic              rd;
        logic [DATA_W-1:0] odata;
        logic              wr;
        logic              lwr;
        logic              busy;
    } amqp_core_st_t;

    amqp_core_st_t     s_q;
    amqp_core_st_t     s_d;
    amqp_stream_if     rb ();
    logic [DATA_W-1:0] outq_pre;
    logic              outq_pre_valid;
    logic              outq_pre_ready;
    logic              rd_ret;

    // ----------------------------------------
    // Read-back buffer feeding output queue
    // ----------------------------------------
    amqp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rb_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_data   (rb.data),
        .in_valid  (rb.valid),
        .in_ready  (rb.ready),
        .out_data  (outq_pre),
        .out_valid (outq_pre_valid),
        .out_ready (outq_pre_ready)
    );

    // Data returned RD_LAT cycles after request
    assign rd_ret  = (s_q.st == AMQP_MWAIT) && (s_q.lat == CNT_W'(RD_LAT));
    assign rb.data  = mem_read_data;
    assign rb.valid = rd_ret;
    // Output side takes a new word only when none pending or pending accepted
    assign outq_pre_ready = !s_q.wr || outq_not_full;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d     = s_q;
        s_d.ce  = 1'b0;
        s_d.we  = 1'b0;
        s_d.rd  = 1'b0;
        s_d.lwr = 1'b0;
        // Output queue write side only, held while full
        if (s_q.wr && outq_not_full) begin
            s_d.wr   = 1'b0;
            s_d.sent = s_q.sent + 1'b1;
            if (s_q.sent + 1'b1 == s_q.len) begin
                s_d.lwr = 1'b1;
            end
        end
        if (outq_pre_valid && outq_pre_ready) begin
            s_d.wr    = 1'b1;
            s_d.odata = outq_pre;
        end
        case (s_q.st)
            AMQP_IDLE: begin
                if (block_start_request && xfer_len != CNT_RST) begin
                    s_d.st   = AMQP_QRD;
                    s_d.len  = xfer_len;
                    s_d.idx  = CNT_RST;
                    s_d.sent = CNT_RST;
                    s_d.busy = 1'b1;
                end
            end
            AMQP_QRD: begin
                if (s_q.rd) begin
                    // Word under the strobe taken at this edge
                    s_d.ce    = 1'b1;
                    s_d.we    = 1'b1;
                    s_d.addr  = ADDR_W'(s_q.idx);
                    s_d.wdata = inq_data;
                    s_d.idx   = s_q.idx + 1'b1;
                    if (s_q.idx + 1'b1 == s_q.len) begin
                        s_d.st  = AMQP_MRD;
                        s_d.idx = CNT_RST;
                    end
                end else if (inq_not_empty) begin
                    s_d.rd = 1'b1;
                end
            end
            AMQP_MRD: begin
                if (rb.ready) begin
                    s_d.ce   = 1'b1;
                    s_d.addr = ADDR_W'(s_q.idx);
                    s_d.lat  = CNT_RST;
                    s_d.st   = AMQP_MWAIT;
                end
            end
            AMQP_MWAIT: begin
                s_d.lat = s_q.lat + 1'b1;
                if (rd_ret) begin
                    s_d.idx = s_q.idx + 1'b1;
                    s_d.st  = (s_q.idx + 1'b1 == s_q.len) ? AMQP_QWR : AMQP_MRD;
                end
            end
            AMQP_QWR: begin
                if (s_d.sent == s_q.len) begin
                    s_d.st   = AMQP_IDLE;
                    s_d.busy = 1'b0;
                end
            end
            default: begin
                s_d.st = AMQP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_q       <= '0;
            s_q.st    <= AMQP_IDLE;
            s_q.addr  <= ADDR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign busy            = s_q.busy;
    assign mem_addr        = s_q.addr;
    assign mem_chip_en     = s_q.ce;
    assign mem_write_en    = s_q.we;
    assign mem_write_data  = s_q.wdata;
    assign inq_read        = s_q.rd;
    assign outq_data       = s_q.odata;
    assign outq_write      = s_q.wr && outq_not_full;
    assign outq_last_write = s_q.lwr;
endmodule : amqp_array_ports

/* File: dv/amqp_props.sv */
// Purpose: Port checks of the array port block
// Assumes: One clock, srst synchronous high
// Notes:   Bound to the amqp_array_ports module
`timescale 1ns/1ps
module amqp_props (
    input wire logic                       core_clk,
    input wire logic                       srst,
    input wire logic                       block_start_request,
    input wire logic [amqp_pkg::CNT_W-1:0] xfer_len,
    input wire logic                       busy,
    input wire logic                       mem_chip_en,
    input wire logic                       mem_write_en,
    input wire logic                       inq_not_empty,
    input wire logic                       inq_read,
    input wire logic                       outq_not_full,
    input wire logic                       outq_write,
    input wire logic                       outq_last_write
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_take;
        block_start_request && !busy && xfer_len != 8'h00;
    endsequence
    sequence s_mem_rd;
        mem_chip_en && !mem_write_en;
    endsequence
    a_start_sets_busy: assert property (s_take |=> busy) else $error("start not taken");
    a_idle_quiet: assert property (!busy |-> !mem_chip_en && !inq_read && !outq_write)
        else $error("port active while idle");
    a_we_with_ce: assert property (mem_write_en |-> mem_chip_en) else $error("we without ce");
    a_read_cause: assert property (inq_read |-> $past(inq_not_empty))
        else $error("queue read while empty");
    a_read_to_ram: assert property (inq_read |=> mem_chip_en && mem_write_en)
        else $error("queue word not written");
    a_write_gate: assert property (outq_write |-> outq_not_full) else $error("write when full");
    a_last_once: assert property (outq_last_write |-> $past(outq_write) ##1 !outq_last_write)
        else $error("bad last write pulse");
    a_rd_spacing: assert property (s_mem_rd |=> !mem_chip_en) else $error("read spacing");
    a_queue_dir: assert property (!(inq_read && outq_write)) else $error("both queues");
endmodule : amqp_props
bind amqp_array_ports amqp_props p_u (.*);

/* File: dv/amqp_far_model.sv */
// Purpose: External RAM and input queue model
// Assumes: RAM read latency of one cycle
// Notes:   Read data turns over when not read
`timescale 1ns/1ps
module amqp_far_model import amqp_pkg::*; (
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              mem_chip_en,
    input  wire logic              mem_write_en,
    input  wire logic [DATA_W-1:0] mem_write_data,
    output logic      [DATA_W-1:0] mem_read_data,
    input  wire logic              inq_read,
    input  wire logic              in_stall,
    output logic      [DATA_W-1:0] inq_data,
    output logic                   inq_not_empty
);
    logic [DATA_W-1:0] ram [0:255];
    logic [DATA_W-1:0] in_idx_q;
    assign inq_data      = 32'h5a00_0000 + in_idx_q;
    assign inq_not_empty = !in_stall;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            in_idx_q      <= 32'h0000_0000;
            mem_read_data <= 32'h0000_0000;
        end else begin
            if (inq_read) in_idx_q <= in_idx_q + 32'h0000_0001;
            if (mem_chip_en && mem_write_en) ram[mem_addr] <= mem_write_data;
            mem_read_data <= (mem_chip_en && !mem_write_en) ? ram[mem_addr]
                           : ~mem_read_data;
        end
    end
endmodule : amqp_far_model

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench of the array port block
// Assumes: 40 MHz clock, reset held 10 cycles
// Notes:   Words must come out in input order
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
    import amqp_pkg::*;
    logic              core_clk, srst, start, in_stall, ce, we, rd, ne, nf, wr, lw, busy;
    logic [CNT_W-1:0]  len;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rdat, qd, od;
    int                mismatches, cmp_count, cycles, exp_idx, n_out, n_last;
    amqp_array_ports dut_u (.core_clk(core_clk), .srst(srst), .block_start_request(start),
        .xfer_len(len), .busy(busy), .mem_addr(addr), .mem_chip_en(ce), .mem_write_en(we),
        .mem_write_data(wd), .mem_read_data(rdat), .inq_data(qd), .inq_not_empty(ne),
        .inq_read(rd), .outq_data(od), .outq_not_full(nf), .outq_write(wr),
        .outq_last_write(lw));
    amqp_far_model far_u (.core_clk(core_clk), .srst(srst), .mem_addr(addr),
        .mem_chip_en(ce), .mem_write_en(we), .mem_write_data(wd), .mem_read_data(rdat),
        .inq_read(rd), .in_stall(in_stall), .inq_data(qd), .inq_not_empty(ne));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task print_verdict;
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    always @(negedge core_clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            print_verdict();
        end else begin
            if (wr === 1'b1) begin
                `CHK(od, 32'h5a00_0000 + exp_idx, "out word")
                exp_idx++;
                n_out++;
            end
            if (lw === 1'b1) n_last++;
        end
    end
    task automatic go(input logic [CNT_W-1:0] n);
        int k;
        len <= n;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        k = 0;
        while (busy !== 1'b1 && k < 20) begin @(negedge core_clk); k++; end
        k = 0;
        while (busy === 1'b1 && k < 5000) begin @(negedge core_clk); k++; end
        @(posedge core_clk);
    endtask : go
    task automatic t_basic;
        int b, o, l;
        b = exp_idx; o = n_out; l = n_last;
        go(8'h04);
        `CHK(n_out - o, 4, "word count")
        `CHK(n_last - l, 1, "last count")
        for (int i = 0; i < 4; i++) `CHK(far_u.ram[i], 32'h5a00_0000 + b + i, "ram")
    endtask : t_basic
    task automatic t_stall;
        int o, l;
        o = n_out;
        l = n_last;
        in_stall <= 1'b1;
        nf <= 1'b0;
        fork
            go(8'h14);
            begin
                repeat (8) @(posedge core_clk);
                in_stall <= 1'b0;
                repeat (80) @(negedge core_clk);
                `CHK(od, 32'h5a00_0000 + exp_idx, "held word")
                @(posedge core_clk);
                nf <= 1'b1;
            end
        join
        `CHK(n_out - o, 20, "buffered count")
        `CHK(n_last - l, 1, "stall last count")
    endtask : t_stall
    task automatic t_refuse;
        go(8'h00);
        repeat (4) @(negedge core_clk);
        `CHK(busy, 1'b0, "zero length")
        @(posedge core_clk);
    endtask : t_refuse
    initial begin
        srst = 1'b1; start = 1'b0; len = 8'h00; in_stall = 1'b0; nf = 1'b1;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_basic();
        t_stall();
        t_refuse();
        print_verdict();
    end
endmodule : tb_top
